// ===== oad_decode.sv
// Contract
// - indirect address from active bank pointer 0/1
// - indirect read above 127 gives undefined byte
// - indirect write above 127 silently dropped
// - code-table/external moves address outside memories
// - only data pointer load takes two bytes
// - direct 0-127 RAM, 128-255 hardware registers
// - undefined register read undefined, write ignored
// - indirect above 127 never reaches registers
// - bit 0-127 maps onto RAM bytes 32-47
// - bit 128-255 maps onto hardware register bits
// - bits within a byte numbered 0 to 7
// - status register flag and bank bit layout
// - timer control upper half layout
// - timer control lower half interrupt bits
// - serial control register bit layout
// - interrupt enable register bit layout
// - interrupt priority register bit layout
// - port three carries alternate pin functions
// - port one latch at direct address 90h
// - general registers from status-selected bank
`timescale 1ns/1ns
`default_nettype none
module oad_decode
    import oad_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire oad_req_t req_i,
    input wire oad_evt_t evt_i,
    output oad_rsp_t rsp_o,
    output oad_ext_t ext_o,
    output logic [15:0] data_pointer_o,
    output logic [7:0] processor_status_o,
    output logic [7:0] timer_control_o,
    output logic [7:0] serial_control_o,
    output logic [7:0] interrupt_enable_o,
    output logic [7:0] interrupt_priority_o,
    output logic [7:0] port_one_o,
    output logic [7:0] port_three_o
);

    typedef struct packed {
        logic [127:0][7:0] ram;
        logic [7:0] processor_status;
        logic [7:0] timer_control;
        logic [7:0] serial_control;
        logic [7:0] interrupt_enable;
        logic [7:0] interrupt_priority;
        logic [7:0] port_one;
        logic [7:0] port_three;
        logic [15:0] data_pointer;
        oad_rsp_t rsp;
        oad_ext_t ext;
    } oad_state_t;

    oad_state_t s;
    oad_state_t next_s;

    // true for every implemented register; all sit on multiples of eight
    function automatic logic reg_defined(input logic [7:0] a);
        reg_defined = (a == ADDR_TIMER_CONTROL) || (a == ADDR_PORT_ONE) ||
            (a == ADDR_SERIAL_CONTROL) || (a == ADDR_INTERRUPT_ENABLE) ||
            (a == ADDR_PORT_THREE) || (a == ADDR_INTERRUPT_PRIORITY) ||
            (a == ADDR_PROCESSOR_STATUS);
    endfunction

    function automatic logic [7:0] reg_read(input oad_state_t st, input logic [7:0] a);
        case (a)
            ADDR_TIMER_CONTROL: reg_read = st.timer_control;
            ADDR_PORT_ONE: reg_read = st.port_one;
            ADDR_SERIAL_CONTROL: reg_read = st.serial_control;
            ADDR_INTERRUPT_ENABLE: reg_read = st.interrupt_enable;
            ADDR_PORT_THREE: reg_read = st.port_three;
            ADDR_INTERRUPT_PRIORITY: reg_read = st.interrupt_priority;
            ADDR_PROCESSOR_STATUS: reg_read = st.processor_status;
            default: reg_read = UNDEF_BYTE;
        endcase
    endfunction

    // writable bits per register; reserved bits stay zero so reads never show junk
    function automatic logic [7:0] reg_mask(input logic [7:0] a);
        case (a)
            ADDR_PROCESSOR_STATUS: reg_mask = MASK_STATUS;
            ADDR_INTERRUPT_ENABLE: reg_mask = MASK_ENABLE;
            ADDR_INTERRUPT_PRIORITY: reg_mask = MASK_PRIORITY;
            default: reg_mask = ~RST_ZERO;
        endcase
    endfunction

    // byte that holds bit address b; numbers above 127 land on register bytes
    function automatic logic [7:0] bit_byte_addr(input logic [7:0] b);
        if (!b[7])
        begin
            bit_byte_addr = BIT_RAM_BASE + {4'h0, b[6:3]};
        end
        else
        begin
            bit_byte_addr = {b[7:3], 3'b000};
        end
    endfunction

    // register-file index of general register r in bank b
    function automatic logic [6:0] gen_index(input logic [1:0] b, input logic [2:0] r);
        gen_index = {2'b00, b, r};
    endfunction

    logic [1:0] bank;
    logic [7:0] ptr_zero;
    logic [7:0] ptr_one;
    logic [7:0] ptr;
    logic [7:0] da;
    logic da_ok;
    logic ram_hit;
    logic reg_hit;
    logic ram_we;
    logic reg_we;
    logic is_bit;
    logic [2:0] bpos;
    logic [7:0] old_byte;
    logic [7:0] new_byte;

    always_comb
    begin
        next_s = s;
        next_s.rsp.valid = 1'b0;
        next_s.ext.code_rd = 1'b0;
        next_s.ext.ext_rd = 1'b0;
        next_s.ext.ext_wr = 1'b0;
        bank = {s.processor_status[BANK_SELECT_HI_POS], s.processor_status[BANK_SELECT_LO_POS]};
        // pointer from bank
        // both pointers read every cycle; the select only steers the result
        ptr_zero = s.ram[gen_index(bank, 3'h0)];
        ptr_one = s.ram[gen_index(bank, 3'h1)];
        if (req_i.sel[0])
        begin
            ptr = ptr_one;
        end
        else
        begin
            ptr = ptr_zero;
        end
        da = req_i.addr;
        da_ok = 1'b0;
        ram_hit = 1'b0;
        reg_hit = 1'b0;
        ram_we = 1'b0;
        reg_we = 1'b0;
        is_bit = 1'b0;
        bpos = req_i.addr[2:0];
        old_byte = UNDEF_BYTE;
        new_byte = req_i.wdata;

        if (req_i.valid)
        begin
            case (req_i.kind)
                KIND_DIRECT:
                begin
                    da = req_i.addr;
                    da_ok = 1'b1;
                end
                KIND_INDIRECT:
                begin
                    da = ptr;
                    da_ok = (ptr <= RAM_LIMIT);
                end
                KIND_GENERAL:
                begin
                    da = {1'b0, gen_index(bank, req_i.sel)};
                    da_ok = 1'b1;
                end
                KIND_BIT:
                begin
                    is_bit = 1'b1;
                    da_ok = 1'b1;
                    da = bit_byte_addr(req_i.addr);
                end
                KIND_CODE_TABLE:
                begin
                    next_s.ext.code_rd = 1'b1;
                    next_s.ext.addr = ptr;
                end
                KIND_EXTERNAL:
                begin
                    next_s.ext.ext_rd = !req_i.wr;
                    next_s.ext.ext_wr = req_i.wr;
                    next_s.ext.addr = ptr;
                    next_s.ext.wdata = req_i.wdata;
                end
                KIND_LOAD_POINTER:
                begin
                    next_s.data_pointer = {req_i.imm_hi, req_i.wdata};
                    next_s.rsp.valid = 1'b1;
                    next_s.rsp.rdata = req_i.wdata;
                end
                KIND_IMMEDIATE:
                begin
                    next_s.rsp.valid = 1'b1;
                    next_s.rsp.rdata = req_i.wdata;
                end
                default:
                begin
                    da_ok = 1'b0;
                end
            endcase

            // one decode of where the access lands, shared by read and write
            ram_hit = da_ok && !da[7];
            reg_hit = da_ok && da[7] && reg_defined(da);
            ram_we = req_i.wr && ram_hit;
            reg_we = req_i.wr && reg_hit;

            if (req_i.kind inside {KIND_DIRECT, KIND_INDIRECT, KIND_GENERAL, KIND_BIT})
            begin
                next_s.rsp.valid = 1'b1;
                if (ram_hit)
                begin
                    old_byte = s.ram[da[6:0]];
                end
                else if (reg_hit)
                begin
                    old_byte = reg_read(s, da);
                end
                if (is_bit)
                begin
                    next_s.rsp.rdata = {7'h00, old_byte[bpos]};
                    new_byte = old_byte;
                    new_byte[bpos] = req_i.wdata[0];
                end
                else
                begin
                    next_s.rsp.rdata = old_byte;
                end

                if (ram_we)
                begin
                    next_s.ram[da[6:0]] = new_byte;
                end
                else if (reg_we)
                begin
                    case (da)
                        ADDR_TIMER_CONTROL: next_s.timer_control = new_byte;
                        ADDR_PORT_ONE: next_s.port_one = new_byte;
                        ADDR_SERIAL_CONTROL: next_s.serial_control = new_byte;
                        ADDR_INTERRUPT_ENABLE: next_s.interrupt_enable = new_byte & reg_mask(da);
                        ADDR_PORT_THREE: next_s.port_three = new_byte;
                        ADDR_INTERRUPT_PRIORITY: next_s.interrupt_priority = new_byte & reg_mask(da);
                        ADDR_PROCESSOR_STATUS: next_s.processor_status = new_byte & reg_mask(da);
                        default: next_s.port_one = next_s.port_one;
                    endcase
                end
            end
        end

        // hardware sets win over a clearing write in the same cycle
        // timer wrap flags, outside interrupt latches and serial done flags
        if (evt_i.timer_b_wrap)
        begin
            next_s.timer_control[TIMER_B_WRAP_FLAG_POS] = 1'b1;
        end
        if (evt_i.timer_a_wrap)
        begin
            next_s.timer_control[TIMER_A_WRAP_FLAG_POS] = 1'b1;
        end
        if (evt_i.outside_irq_b)
        begin
            next_s.timer_control[OUTSIDE_IRQ_B_LATCHED_POS] = 1'b1;
        end
        if (evt_i.outside_irq_a)
        begin
            next_s.timer_control[OUTSIDE_IRQ_A_LATCHED_POS] = 1'b1;
        end
        if (evt_i.tx_done)
        begin
            next_s.serial_control[TX_DONE_FLAG_POS] = 1'b1;
        end
        if (evt_i.rx_done)
        begin
            next_s.serial_control[RX_DONE_FLAG_POS] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            // RAM content is left alone; it is unpredictable after reset anyway
            s.ram <= s.ram;
            s.processor_status <= RST_ZERO;
            s.timer_control <= RST_ZERO;
            s.serial_control <= RST_ZERO;
            s.interrupt_enable <= RST_ZERO;
            s.interrupt_priority <= RST_ZERO;
            s.port_one <= RST_PORT;
            s.port_three <= RST_PORT;
            s.data_pointer <= {RST_ZERO, RST_ZERO};
            s.rsp <= '0;
            s.ext <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rsp_o = s.rsp;
    assign ext_o = s.ext;
    assign data_pointer_o = s.data_pointer;
    assign processor_status_o = s.processor_status;
    assign timer_control_o = s.timer_control;
    assign serial_control_o = s.serial_control;
    assign interrupt_enable_o = s.interrupt_enable;
    assign interrupt_priority_o = s.interrupt_priority;
    assign port_one_o = s.port_one;
    assign port_three_o = s.port_three;

endmodule
`default_nettype wire

// ===== oad_decode_bench.sv
`timescale 1ns/1ns
`default_nettype none
module oad_decode_bench;
    import oad_pkg::*;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    oad_req_t req_i = '0;
    oad_evt_t evt_i = '0;
    oad_rsp_t rsp_o;
    oad_ext_t ext_o;
    logic [15:0] data_pointer_o;
    logic [7:0] processor_status_o, timer_control_o, serial_control_o;
    logic [7:0] interrupt_enable_o, interrupt_priority_o, port_one_o, port_three_o;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    logic [7:0] rd, d, a;
    logic [7:0] regs [7] = '{8'h88, 8'h90, 8'h98, 8'ha8, 8'hb0, 8'hb8, 8'hd0};
    logic [7:0] hwb [6] = '{8'h8e, 8'haf, 8'hbc, 8'h9d, 8'hb1, 8'hd7};

    always #10 mclk_i = ~mclk_i;
    oad_decode i_dut (.mclk_i, .resetn_i, .req_i, .evt_i, .rsp_o, .ext_o, .data_pointer_o,
        .processor_status_o, .timer_control_o, .serial_control_o, .interrupt_enable_o,
        .interrupt_priority_o, .port_one_o, .port_three_o);

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge mclk_i)
    begin
        cycles++;
        // generous: the sequence needs some 250 cycles
        if (cycles == 3000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask

    // request held one cycle, answer read once it has landed
    task automatic acc(input oad_kind_t k, input logic w, input logic [2:0] s, input logic [7:0] ad,
        input logic [7:0] wd, input logic [7:0] hi = 8'h00);
        @(posedge mclk_i);
        #1;
        req_i = '{1'b1, k, w, s, ad, wd, hi};
        @(posedge mclk_i);
        #1;
        req_i.valid = 1'b0;
        rd = rsp_o.rdata;
    endtask

    task automatic dw(input logic [7:0] ad, input logic [7:0] wd);
        acc(KIND_DIRECT, 1'b1, 3'h0, ad, wd);
    endtask

    task automatic dr(input logic [7:0] ad);
        acc(KIND_DIRECT, 1'b0, 3'h0, ad, 8'h00);
    endtask

    function automatic logic [7:0] msk(input logic [7:0] ad);
        case (ad)
            8'hd0: msk = 8'hfd;
            8'ha8: msk = 8'h9f;
            8'hb8: msk = 8'h1f;
            default: msk = 8'hff;
        endcase
    endfunction

    initial
    begin
        n = $urandom(32'h90a3);
        repeat (16) @(posedge mclk_i);
        #1;
        resetn_i = 1'b1;
        chk("status_timer", 16'h0000, {processor_status_o, timer_control_o});
        chk("serial_enable", 16'h0000, {serial_control_o, interrupt_enable_o});
        chk("prio_port1", 16'h00ff, {interrupt_priority_o, port_one_o});
        chk("port3_data_pointer", 16'hff00, {port_three_o, data_pointer_o[7:0]});
        for (n = 0; n < 8; n++)
        begin
            a = 8'($urandom_range(127));
            d = 8'($urandom);
            dw(a, d);
            dr(a);
            chk("ram", 16'(d), 16'(rd));
        end
        for (n = 0; n < 7; n++)
        begin
            d = 8'($urandom);
            dw(regs[n], d);
            dr(regs[n]);
            chk("reg", 16'(d & msk(regs[n])), 16'(rd));
        end
        dw(8'h80, 8'h12);
        dr(8'h80);
        chk("undef", 16'h00ff, 16'(rd));
        for (n = 0; n < 4; n++)
        begin
            a = 8'($urandom_range(127, 48));
            d = 8'($urandom);
            dw(8'hd0, 8'(n << 3));
            dw(8'(n * 8 + 1), a);
            acc(KIND_INDIRECT, 1'b1, 3'h1, 8'h00, d);
            dr(a);
            chk("ind_wr", 16'(d), 16'(rd));
            acc(KIND_INDIRECT, 1'b0, 3'h1, 8'h00, 8'h00);
            chk("ind_rd", 16'(d), 16'(rd));
        end
        // pointer past the ram must not alias onto port one
        dw(8'h90, 8'h33);
        dw(8'h19, 8'h90);
        acc(KIND_INDIRECT, 1'b1, 3'h1, 8'h00, 8'h3c);
        acc(KIND_INDIRECT, 1'b0, 3'h1, 8'h00, 8'h00);
        chk("ind_hi", 16'h00ff, 16'(rd));
        dr(8'h90);
        chk("ind_hi_wr", 16'h0033, 16'(rd));
        for (n = 0; n < 6; n++)
        begin
            a = 8'($urandom_range(127));
            dw({4'h2, a[6:3]}, 8'h00);
            acc(KIND_BIT, 1'b1, 3'h0, a, 8'h01);
            dr({4'h2, a[6:3]});
            chk("ram_bit", 16'(8'h01 << a[2:0]), 16'(rd));
        end
        for (n = 0; n < 6; n++)
        begin
            a = hwb[n];
            dw({a[7:3], 3'h0}, 8'h00);
            acc(KIND_BIT, 1'b1, 3'h0, a, 8'h01);
            dr({a[7:3], 3'h0});
            chk("hw_bit", 16'(8'h01 << a[2:0]), 16'(rd));
            acc(KIND_BIT, 1'b0, 3'h0, a, 8'h00);
            chk("bit_rd", 16'h0001, 16'(rd[0]));
        end
        d = 8'($urandom);
        a = 8'($urandom);
        acc(KIND_LOAD_POINTER, 1'b0, 3'h0, 8'h00, d, a);
        chk("data_pointer", {a, d}, data_pointer_o);
        acc(KIND_IMMEDIATE, 1'b0, 3'h0, 8'h00, d);
        chk("imm", 16'(d), 16'(rd));
        dw(8'h00, a);
        acc(KIND_EXTERNAL, 1'b1, 3'h0, 8'h00, d);
        chk("ext", {a, d}, {ext_o.addr, ext_o.wdata});
        chk("ext_wr", 16'h0001, 16'(ext_o.ext_wr));
        acc(KIND_CODE_TABLE, 1'b0, 3'h0, 8'h00, 8'h00);
        chk("code", {8'h01, a}, {7'h00, ext_o.code_rd, ext_o.addr});
        dw(8'hd0, 8'h10);
        n = $urandom_range(7);
        acc(KIND_GENERAL, 1'b1, 3'(n), 8'h00, d);
        dr(8'(16 + n));
        chk("gen_wr", 16'(d), 16'(rd));
        acc(KIND_GENERAL, 1'b0, 3'(n), 8'h00, 8'h00);
        chk("gen_rd", 16'(d), 16'(rd));
        dw(8'h11, a);
        acc(KIND_EXTERNAL, 1'b0, 3'h1, 8'h00, 8'h00);
        chk("ext_rd", {8'h01, a}, {7'h00, ext_o.ext_rd, ext_o.addr});
        chk("ext_rd_nowr", 16'h0000, 16'(ext_o.ext_wr));
        dw(8'h88, 8'h00);
        dw(8'h98, 8'h00);
        @(posedge mclk_i);
        #1;
        evt_i = '1;
        @(posedge mclk_i);
        #1;
        evt_i = '0;
        chk("events", 16'haa03, {timer_control_o, serial_control_o});
        // clearing write and a wrap event in one cycle: the event must win
        @(posedge mclk_i);
        #1;
        req_i = '{1'b1, KIND_DIRECT, 1'b1, 3'h0, 8'h88, 8'h00, 8'h00};
        evt_i.timer_a_wrap = 1'b1;
        @(posedge mclk_i);
        #1;
        req_i.valid = 1'b0;
        evt_i = '0;
        chk("set_wins", 16'h0020, 16'(timer_control_o));
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== oad_decode_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module oad_decode_monitor
    import oad_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire oad_req_t req_i,
    input wire oad_evt_t evt_i,
    input wire oad_rsp_t rsp_o,
    input wire oad_ext_t ext_o,
    input wire logic [15:0] data_pointer_o,
    input wire logic [7:0] processor_status_o,
    input wire logic [7:0] timer_control_o,
    input wire logic [7:0] serial_control_o,
    input wire logic [7:0] interrupt_enable_o,
    input wire logic [7:0] interrupt_priority_o,
    input wire logic [7:0] port_one_o,
    input wire logic [7:0] port_three_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    logic dw;
    logic [2:0] k;
    assign k = req_i.kind;
    assign dw = req_i.valid && req_i.wr && req_i.kind == KIND_DIRECT;

    a_rsp_on_chip: assert property (req_i.valid && k != KIND_CODE_TABLE && k != KIND_EXTERNAL |=> rsp_o.valid)
        else $error("no answer to on-chip request");
    a_code_no_rsp: assert property (req_i.valid && k == KIND_CODE_TABLE |=> ext_o.code_rd && !rsp_o.valid)
        else $error("code read strobe wrong");
    a_ext_write: assert property (req_i.valid && req_i.wr && k == KIND_EXTERNAL
        |=> ext_o.ext_wr && ext_o.wdata == $past(req_i.wdata))
        else $error("external write wrong");
    a_pointer_load: assert property (req_i.valid && k == KIND_LOAD_POINTER
        |=> data_pointer_o == {$past(req_i.imm_hi), $past(req_i.wdata)})
        else $error("data pointer load wrong");
    a_port_one_wr: assert property (dw && req_i.addr == 8'h90 |=> port_one_o == $past(req_i.wdata))
        else $error("port one write wrong");
    a_enable_wr: assert property (dw && req_i.addr == 8'ha8
        |=> interrupt_enable_o == ($past(req_i.wdata) & 8'h9f))
        else $error("enable write wrong");
    a_undef_wr: assert property (dw && req_i.addr == 8'h80 |=> $stable(processor_status_o)
        && $stable(port_one_o) && $stable(port_three_o) && $stable(interrupt_enable_o))
        else $error("reserved write changed a register");
    a_indirect_apart: assert property (req_i.valid && req_i.wr && k == KIND_INDIRECT
        |=> $stable({port_one_o, interrupt_enable_o, interrupt_priority_o}))
        else $error("indirect write reached a register");
    a_run_bit_set: assert property (req_i.valid && req_i.wr && k == KIND_BIT && req_i.addr == 8'h8e
        |=> timer_control_o[6] == $past(req_i.wdata[0]))
        else $error("run bit write wrong");
    a_wrap_event: assert property (evt_i.timer_b_wrap |=> timer_control_o[7])
        else $error("wrap flag not set");
    a_latch_event: assert property (evt_i.outside_irq_a |=> timer_control_o[1])
        else $error("irq latch not set");
    a_reserved_zero: assert property (interrupt_priority_o[7:5] == 3'h0 && !processor_status_o[1])
        else $error("reserved bit set");
endmodule
bind oad_decode oad_decode_monitor i_mon (.mclk_i, .resetn_i, .req_i, .evt_i, .rsp_o, .ext_o, .data_pointer_o,
    .processor_status_o, .timer_control_o, .serial_control_o, .interrupt_enable_o, .interrupt_priority_o,
    .port_one_o, .port_three_o);
`default_nettype wire

// ===== oad_pkg.sv
package oad_pkg;

    // direct-space addresses of the hardware registers
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_PORT_ONE = 8'h90;
    localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_PORT_THREE = 8'hb0;
    localparam logic [7:0] ADDR_INTERRUPT_PRIORITY = 8'hb8;
    localparam logic [7:0] ADDR_PROCESSOR_STATUS = 8'hd0;

    // address space limits
    localparam logic [7:0] RAM_LIMIT = 8'h7f;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;

    // reset and filler values
    localparam logic [7:0] RST_PORT = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] UNDEF_BYTE = 8'hff;

    // implemented bits; the rest read as zero
    localparam logic [7:0] MASK_STATUS = 8'hfd;
    localparam logic [7:0] MASK_ENABLE = 8'h9f;
    localparam logic [7:0] MASK_PRIORITY = 8'h1f;

    // processor status fields
    localparam int CARRY_FLAG_POS = 7;
    localparam int HALF_CARRY_FLAG_POS = 6;
    localparam int USER_FLAG_ZERO_POS = 5;
    localparam int BANK_SELECT_HI_POS = 4;
    localparam int BANK_SELECT_LO_POS = 3;
    localparam int SIGNED_RANGE_FLAG_POS = 2;

    // timer control fields
    localparam int TIMER_B_WRAP_FLAG_POS = 7;
    localparam int TIMER_B_RUN_POS = 6;
    localparam int TIMER_A_WRAP_FLAG_POS = 5;
    localparam int TIMER_A_RUN_POS = 4;
    localparam int OUTSIDE_IRQ_B_LATCHED_POS = 3;
    localparam int OUTSIDE_IRQ_B_EDGE_MODE_POS = 2;
    localparam int OUTSIDE_IRQ_A_LATCHED_POS = 1;
    localparam int OUTSIDE_IRQ_A_EDGE_MODE_POS = 0;

    // serial control fields
    localparam int RX_ENABLE_POS = 4;
    localparam int TX_NINTH_BIT_POS = 3;
    localparam int RX_NINTH_BIT_POS = 2;
    localparam int TX_DONE_FLAG_POS = 1;
    localparam int RX_DONE_FLAG_POS = 0;

    typedef enum logic [2:0] {
        KIND_DIRECT = 3'h0,
        KIND_INDIRECT = 3'h1,
        KIND_BIT = 3'h2,
        KIND_GENERAL = 3'h3,
        KIND_CODE_TABLE = 3'h4,
        KIND_EXTERNAL = 3'h5,
        KIND_LOAD_POINTER = 3'h6,
        KIND_IMMEDIATE = 3'h7
    } oad_kind_t;

    typedef struct packed {
        logic valid;
        oad_kind_t kind;
        logic wr;
        logic [2:0] sel;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] imm_hi;
    } oad_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } oad_rsp_t;

    typedef struct packed {
        logic code_rd;
        logic ext_rd;
        logic ext_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } oad_ext_t;

    // hardware events that set sticky flags
    typedef struct packed {
        logic timer_a_wrap;
        logic timer_b_wrap;
        logic outside_irq_a;
        logic outside_irq_b;
        logic tx_done;
        logic rx_done;
    } oad_evt_t;

endpackage
